// ### logic/ssp_pkg.sv
// shared constants and types of the serial status, protection and read block
`default_nettype none
package ssp_pkg;

    // command codes, shifted in most significant bit first
    localparam logic [7:0] CMD_LATCH_SET = 8'h06;
    localparam logic [7:0] CMD_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_ARRAY_READ = 8'h03;

    // frame lengths in serial clock edges
    localparam logic [5:0] CMD_BITS = 6'h08;
    localparam logic [5:0] STATUS_WRITE_BITS = 6'h10;
    localparam logic [5:0] READ_HEADER_BITS = 6'h20;
    localparam logic [5:0] BIT_COUNT_MAX = 6'h3F;

    // status byte field positions
    localparam int STATUS_BUSY_POS = 0;
    localparam int STATUS_LATCH_POS = 1;
    localparam int STATUS_PROTECT_LSB = 2;
    localparam int STATUS_PROTECT_MSB = 5;
    localparam int STATUS_DIR_POS = 6;
    localparam int STATUS_LOCK_POS = 7;

    // power-up value of the nonvolatile fields (lock, direction, protect)
    localparam logic [5:0] STATUS_NV_RESET = 6'h00;

    // array geometry: 128 sectors selected by address bits 23:17
    localparam int ADDR_BITS = 24;
    localparam int SECTOR_LSB = 17;
    localparam int SECTOR_BITS = 7;

    // self-timed status update, rounded up to whole system clocks
    localparam int SYS_CLK_PERIOD_NS = 10;
    localparam int STATUS_UPDATE_TIME_NS = 1000;
    localparam int STATUS_UPDATE_CYCLES =
        (STATUS_UPDATE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    // status byte as seen by the host
    typedef struct packed {
        logic status_lock_bit;
        logic region_direction_bit;
        logic [3:0] protect_level;
        logic write_latch_flag;
        logic cycle_busy_flag;
    } status_t;

    // what a finished frame leaves behind for the system clock side
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
        logic [5:0] bits;
    } frame_t;

endpackage
`default_nettype wire

// ### logic/sector_protect_decode.sv
// decode of the protected sector range from the protect level fields
`timescale 1ns/1ns
`default_nettype none
module sector_protect_decode (
    // protect settings
    input wire logic [3:0] protect_level,
    input wire logic region_direction_bit,
    // sector under test
    input wire logic [6:0] sector,
    output logic locked
);
    logic [7:0] span;

    // protected sector count doubles per code step, from 1 up to 64
    always_comb begin
        span = 8'h00;
        if (protect_level[2:0] != 3'h0) begin
            span = 8'h01 << (protect_level[2:0] - 3'h1);
        end
        if (protect_level[3]) begin
            locked = 1'b1;
        end else if (region_direction_bit) begin
            locked = ({1'b0, sector} < span);
        end else begin
            locked = ({1'b0, sector} >= (8'h80 - span)) && (span != 8'h00);
        end
    end
endmodule
`default_nettype wire

// ### logic/array_store.sv
// array contents: written on the system clock, read on the serial clock
`timescale 1ns/1ns
`default_nettype none
module array_store #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 10
) (
    // write port
    input wire logic wr_clk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    // read port, data registered
    input wire logic rd_clk,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

    // write side
    always_ff @(posedge wr_clk) begin
        if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
    end

    // read side holds its word until the next enable
    always_ff @(posedge rd_clk) begin
        if (rd_en) begin
            rd_data <= cells[rd_addr];
        end
    end
endmodule
`default_nettype wire

// ### logic/serial_status_protect_and_read.sv
// serial status byte, protection, status write cycle and array read
`timescale 1ns/1ns
`default_nettype none
module serial_status_protect_and_read #(
    parameter int MEM_ADDR_W = 10,
    parameter int UPDATE_CYCLES = ssp_pkg::STATUS_UPDATE_CYCLES
) (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // serial link pins
    input wire logic spi_clk,
    input wire logic select_n,
    input wire logic serial_in_line,
    input wire logic write_protect_n,
    output logic serial_out,
    output logic serial_out_oe_n,
    // program and erase engine hooks
    input wire logic ext_cycle_busy,
    input wire logic ext_cycle_done,
    input wire logic page_write_req,
    input wire logic [23:0] page_write_addr,
    input wire logic [7:0] page_write_data,
    output logic page_write_refused,
    input wire logic clear_all_req,
    output logic clear_all_grant,
    output logic clear_all_refused,
    // status view
    output ssp_pkg::status_t status_view
);
    // ---------------- link clock domain ----------------
    logic fresh;
    logic [5:0] bit_cnt;
    logic [5:0] pre_cnt;
    logic [5:0] next_bit_cnt;
    logic [7:0] cmd;
    logic [7:0] next_cmd;
    logic [23:0] addr_sr;
    logic [23:0] next_addr;
    logic [23:0] rd_addr;
    logic read_on;
    logic status_on;
    logic read_start;
    logic mem_rd_en;
    logic [23:0] mem_rd_addr;
    logic [7:0] mem_rd_data;
    logic [2:0] out_cnt;
    logic [6:0] out_shift;
    logic [7:0] out_byte;
    ssp_pkg::status_t st_l1;
    ssp_pkg::status_t st_l2;
    logic page_accept;

    // marks the first rising edge of each frame; select high rearms it
    always_ff @(posedge spi_clk or negedge resetn or posedge select_n) begin
        if (!resetn) begin
            fresh <= 1'b1;
        end else if (select_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // edge count within the frame, and the incoming shift values
    always_comb begin
        pre_cnt = fresh ? 6'h00 : bit_cnt;
        next_bit_cnt = (pre_cnt == ssp_pkg::BIT_COUNT_MAX) ? pre_cnt : pre_cnt + 6'h01;
        next_cmd = {cmd[6:0], serial_in_line};
        next_addr = {addr_sr[22:0], serial_in_line};
        read_start = (pre_cnt == ssp_pkg::READ_HEADER_BITS - 6'h01)
            && (cmd == ssp_pkg::CMD_ARRAY_READ) && !st_l2.cycle_busy_flag;
    end

    // status byte brought over for read-back and busy checks
    always_ff @(posedge spi_clk or negedge resetn) begin
        if (!resetn) begin
            st_l1 <= '0;
            st_l2 <= '0;
        end else begin
            st_l1 <= status_view;
            st_l2 <= st_l1;
        end
    end

    // command byte, then address or data bits on rising edges
    always_ff @(posedge spi_clk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt <= 6'h00;
            cmd <= 8'h00;
            addr_sr <= 24'h000000;
        end else begin
            bit_cnt <= next_bit_cnt;
            if (pre_cnt < ssp_pkg::CMD_BITS) begin
                cmd <= next_cmd;
            end else if (pre_cnt < ssp_pkg::READ_HEADER_BITS) begin
                addr_sr <= next_addr;
            end
        end
    end

    // output phases: status read always allowed, array read only when idle
    always_ff @(posedge spi_clk or negedge resetn) begin
        if (!resetn) begin
            read_on <= 1'b0;
            status_on <= 1'b0;
        end else if (fresh) begin
            read_on <= 1'b0;
            status_on <= 1'b0;
        end else begin
            if (read_start) begin
                read_on <= 1'b1;
            end
            if ((pre_cnt == ssp_pkg::CMD_BITS - 6'h01)
                && (next_cmd == ssp_pkg::CMD_STATUS_READ)) begin
                status_on <= 1'b1;
            end
        end
    end

    // array fetch: header address first, then one fetch per byte loaded
    always_comb begin
        mem_rd_en = read_start || (read_on && (out_cnt == 3'h1));
        mem_rd_addr = read_start ? next_addr : rd_addr;
    end

    // running read address, wrapping past the top of the space
    always_ff @(posedge spi_clk or negedge resetn) begin
        if (!resetn) begin
            rd_addr <= 24'h000000;
        end else if (mem_rd_en) begin
            rd_addr <= mem_rd_addr + 24'h000001;
        end
    end

    array_store #(
        .DATA_W(8),
        .ADDR_W(MEM_ADDR_W)
    ) u_store (
        .wr_clk(sys_clk),
        .wr_en(page_accept),
        .wr_addr(page_write_addr[MEM_ADDR_W-1:0]),
        .wr_data(page_write_data),
        .rd_clk(spi_clk),
        .rd_en(mem_rd_en),
        .rd_addr(mem_rd_addr[MEM_ADDR_W-1:0]),
        .rd_data(mem_rd_data)
    );

    // byte to send; direction bit masked on status read-back
    always_comb begin
        out_byte = read_on ? mem_rd_data : st_l2;
        if (!read_on) begin
            out_byte[ssp_pkg::STATUS_DIR_POS] = 1'b0;
        end
    end

    // output shifter on falling edges, released at once when select rises
    always_ff @(negedge spi_clk or negedge resetn or posedge select_n) begin
        if (!resetn) begin
            out_cnt <= 3'h0;
            out_shift <= 7'h00;
            serial_out <= 1'b0;
            serial_out_oe_n <= 1'b1;
        end else if (select_n) begin
            out_cnt <= 3'h0;
            out_shift <= 7'h00;
            serial_out <= 1'b0;
            serial_out_oe_n <= 1'b1;
        end else if (read_on || status_on) begin
            out_cnt <= out_cnt + 3'h1;
            serial_out_oe_n <= 1'b0;
            if (out_cnt == 3'h0) begin
                serial_out <= out_byte[7];
                out_shift <= out_byte[6:0];
            end else begin
                serial_out <= out_shift[6];
                out_shift <= {out_shift[5:0], 1'b0};
            end
        end
    end

    // ---------------- system clock domain ----------------
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic cs_s4;
    logic wp_s1;
    logic wp_s2;
    ssp_pkg::frame_t fr_s1;
    ssp_pkg::frame_t fr_s2;
    logic frame_end;
    logic busy_all;
    logic hw_lock;
    logic write_latch;
    logic update_run;
    logic [15:0] update_cnt;
    logic [5:0] nv_bits;
    logic [5:0] nv_pending;
    logic status_write_ok;
    logic sector_locked;

    // select passes four flops; write-protect pin and frame summary each pass two
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            cs_s4 <= 1'b1;
            wp_s1 <= 1'b1;
            wp_s2 <= 1'b1;
            fr_s1 <= '0;
            fr_s2 <= '0;
        end else begin
            cs_s1 <= select_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            cs_s4 <= cs_s3;
            wp_s1 <= write_protect_n;
            wp_s2 <= wp_s1;
            fr_s1 <= '{cmd: cmd, data: addr_sr[7:0], bits: bit_cnt};
            fr_s2 <= fr_s1;
        end
    end

    // frame decode one cycle after the summary has settled
    always_comb begin
        frame_end = cs_s3 && !cs_s4;
        busy_all = update_run || ext_cycle_busy;
        hw_lock = nv_bits[5] && !wp_s2;
        status_write_ok = frame_end && !busy_all
            && (fr_s2.cmd == ssp_pkg::CMD_STATUS_WRITE)
            && (fr_s2.bits == ssp_pkg::STATUS_WRITE_BITS)
            && write_latch
            && !hw_lock;
    end

    // self-timed update; new fields land when the timer expires
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            update_run <= 1'b0;
            update_cnt <= 16'h0000;
            nv_pending <= ssp_pkg::STATUS_NV_RESET;
            nv_bits <= ssp_pkg::STATUS_NV_RESET;
        end else if (update_run) begin
            if (update_cnt == 16'h0001) begin
                update_run <= 1'b0;
                nv_bits <= nv_pending;
            end
            update_cnt <= update_cnt - 16'h0001;
        end else if (status_write_ok) begin
            update_run <= 1'b1;
            update_cnt <= 16'(UPDATE_CYCLES);
            nv_pending <= fr_s2.data[7:2];
        end
    end

    // write latch: set command wins over any clear in the same cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            write_latch <= 1'b0;
        end else if (frame_end && !busy_all && (fr_s2.bits == ssp_pkg::CMD_BITS)
            && (fr_s2.cmd == ssp_pkg::CMD_LATCH_SET)) begin
            write_latch <= 1'b1;
        end else if (update_run && (update_cnt == 16'h0001)) begin
            write_latch <= 1'b0;
        end else if (ext_cycle_done) begin
            write_latch <= 1'b0;
        end else if (frame_end && !busy_all && (fr_s2.bits == ssp_pkg::CMD_BITS)
            && (fr_s2.cmd == ssp_pkg::CMD_LATCH_CLEAR)) begin
            write_latch <= 1'b0;
        end
    end

    sector_protect_decode u_decode (
        .protect_level(nv_bits[3:0]),
        .region_direction_bit(nv_bits[4]),
        .sector(page_write_addr[ssp_pkg::SECTOR_LSB +: ssp_pkg::SECTOR_BITS]),
        .locked(sector_locked)
    );

    // engine writes land only in unprotected sectors with the latch set
    assign page_accept = page_write_req && write_latch && !sector_locked;

    // engine answers, one-cycle pulses
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            page_write_refused <= 1'b0;
            clear_all_grant <= 1'b0;
            clear_all_refused <= 1'b0;
        end else begin
            page_write_refused <= page_write_req && !page_accept;
            clear_all_grant <= clear_all_req && write_latch
                && (nv_bits[3:0] == 4'h0);
            clear_all_refused <= clear_all_req && !(write_latch
                && (nv_bits[3:0] == 4'h0));
        end
    end

    // status byte as stored; direction masked only on the serial read
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            status_view <= '0;
        end else begin
            status_view <= '{status_lock_bit: nv_bits[5],
                             region_direction_bit: nv_bits[4],
                             protect_level: nv_bits[3:0],
                             write_latch_flag: write_latch,
                             cycle_busy_flag: busy_all};
        end
    end
endmodule
`default_nettype wire

// ### verif/serial_status_protect_and_read_assertions.sv
// port-level checks of the serial status, protection and read block
`timescale 1ns/1ns
`default_nettype none
module serial_status_protect_and_read_assertions #(
    parameter int UPDATE_CYCLES = ssp_pkg::STATUS_UPDATE_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // serial link
    input wire logic select_n,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    // engine hooks
    input wire logic ext_cycle_busy,
    input wire logic page_write_req,
    input wire logic page_write_refused,
    input wire logic clear_all_req,
    input wire logic clear_all_grant,
    input wire logic clear_all_refused,
    // status view
    input wire ssp_pkg::status_t status_view
);
    localparam int BUSY_LO = UPDATE_CYCLES - 2;
    localparam int BUSY_HI = UPDATE_CYCLES + 2;
    logic busy;
    logic latch;
    logic ext_seen;
    logic [15:0] busy_run;
    assign busy = status_view.cycle_busy_flag;
    assign latch = status_view.write_latch_flag;
    // length of the busy stretch, and whether the engine took part in it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy_run <= 16'h0000;
            ext_seen <= 1'b0;
        end else begin
            busy_run <= busy ? busy_run + 16'h0001 : 16'h0000;
            ext_seen <= ext_cycle_busy | (ext_seen & busy);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // requests made while the status view holds still
    sequence pw_s(logic c);
        page_write_req && c && $stable(status_view);
    endsequence
    sequence clr_s(logic c);
        clear_all_req && c && $stable(status_view);
    endsequence
    AST_OE_IDLE: assert property (select_n |-> serial_out_oe_n && !serial_out)
        else $error("output driven while deselected");
    AST_PW_NOLATCH: assert property (pw_s(!latch) |=> page_write_refused)
        else $error("page write accepted without latch");
    AST_PW_TOP: assert property (pw_s(latch && status_view.protect_level[3]) |=> page_write_refused)
        else $error("page write accepted with top protect set");
    AST_PW_OPEN: assert property (pw_s(latch && status_view.protect_level == 4'h0)
        |=> !page_write_refused)
        else $error("page write refused with nothing protected");
    AST_PW_CAUSE: assert property (!page_write_req |=> !page_write_refused)
        else $error("refusal without request");
    AST_CLR_GRANT: assert property (clr_s(latch && status_view.protect_level == 4'h0)
        |=> clear_all_grant && !clear_all_refused)
        else $error("whole clear not granted");
    AST_CLR_REFUSE: assert property (clear_all_req && status_view.protect_level != 4'h0
        |=> clear_all_refused && !clear_all_grant)
        else $error("whole clear granted while protected");
    AST_NV_HOLD: assert property ($changed(status_view[7:2]) |-> !busy && !latch)
        else $error("protect or lock bits changed outside a finished update");
    AST_BUSY_SPAN: assert property ($fell(busy) && !ext_seen
        |-> busy_run inside {[BUSY_LO:BUSY_HI]})
        else $error("status update length wrong");
endmodule
bind serial_status_protect_and_read serial_status_protect_and_read_assertions #(
    .UPDATE_CYCLES(UPDATE_CYCLES)
) u_chk (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .select_n(select_n),
    .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n),
    .ext_cycle_busy(ext_cycle_busy),
    .page_write_req(page_write_req),
    .page_write_refused(page_write_refused),
    .clear_all_req(clear_all_req),
    .clear_all_grant(clear_all_grant),
    .clear_all_refused(clear_all_refused),
    .status_view(status_view)
);
`default_nettype wire

// ### verif/spi_host_model.sv
// host model that frames commands on the serial link
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    // link driven by the host
    output logic spi_clk,
    output logic select_n,
    output logic serial_in_line,
    // link driven by the device
    input wire logic serial_out,
    input wire logic serial_out_oe_n
);
    // clock stands low and select high between frames
    initial begin
        spi_clk = 1'b0;
        select_n = 1'b1;
        serial_in_line = 1'b1;
    end
    // shift n bits msb first, capture the reply on each rising edge
    task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx,
        output logic drv);
        rx = '0;
        drv = 1'b0;
        #7 select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in_line = tx[i];
            #16 spi_clk = 1'b1;
            rx = {rx[62:0], serial_out};
            drv = drv | !serial_out_oe_n;
            #16 spi_clk = 1'b0;
        end
        #5 select_n = 1'b1;
        serial_in_line = ~serial_in_line;
        #100;
    endtask
endmodule
`default_nettype wire

// ### verif/serial_status_protect_and_read_bench.sv
// self-checking bench for the serial status, protection and read block
`timescale 1ns/1ns
`default_nettype none
module serial_status_protect_and_read_bench;
    localparam int UPD = 250;
    logic sys_clk, resetn, write_protect_n, ext_cycle_busy, ext_cycle_done;
    logic spi_clk, select_n, serial_in_line, serial_out, serial_out_oe_n;
    logic page_write_req, page_write_refused, clear_all_req, clear_all_grant, clear_all_refused;
    logic [23:0] page_write_addr;
    logic [7:0] page_write_data;
    ssp_pkg::status_t status_view;
    int num_errors = 0;
    int samples_checked = 0;
    int corner [6] = '{0, 1, 63, 64, 126, 127};
    int s;
    logic [63:0] rx;
    logic dv;
    logic [7:0] d;
    logic [7:0] b [4];
    serial_status_protect_and_read #(.MEM_ADDR_W(10), .UPDATE_CYCLES(UPD)) dut (
        .sys_clk(sys_clk), .resetn(resetn), .spi_clk(spi_clk), .select_n(select_n),
        .serial_in_line(serial_in_line), .write_protect_n(write_protect_n),
        .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
        .ext_cycle_busy(ext_cycle_busy), .ext_cycle_done(ext_cycle_done),
        .page_write_req(page_write_req), .page_write_addr(page_write_addr),
        .page_write_data(page_write_data), .page_write_refused(page_write_refused),
        .clear_all_req(clear_all_req), .clear_all_grant(clear_all_grant),
        .clear_all_refused(clear_all_refused), .status_view(status_view));
    spi_host_model host (.spi_clk(spi_clk), .select_n(select_n),
        .serial_in_line(serial_in_line), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n));
    // system clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // one host frame, then back onto a system edge
    task automatic frame(input logic [63:0] tx, input int n);
        host.xfer(tx, n, rx, dv);
        @(posedge sys_clk);
    endtask
    // bounded wait for the busy flag to drop
    task automatic settle();
        for (int i = 0; i < 600 && status_view.cycle_busy_flag !== 1'b0; i++) begin
            @(posedge sys_clk);
        end
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic wsr(input logic [7:0] v);
        frame(8'h06, 8);
        frame({8'h01, v}, 16);
        settle();
    endtask
    task automatic pw(input logic [23:0] a, input logic [7:0] v, input logic e);
        page_write_req <= 1'b1;
        page_write_addr <= a;
        page_write_data <= v;
        @(posedge sys_clk);
        page_write_req <= 1'b0;
        #1 chk(page_write_refused, e);
        @(posedge sys_clk);
    endtask
    task automatic clr(input logic e);
        clear_all_req <= 1'b1;
        @(posedge sys_clk);
        clear_all_req <= 1'b0;
        #1 chk({clear_all_grant, clear_all_refused}, {e, !e});
        @(posedge sys_clk);
    endtask
    // expected protection of a sector
    function automatic logic prot(input logic [3:0] p, input logic t, input int sec);
        int n;
        n = (p[2:0] == 3'h0) ? 0 : (1 << (p[2:0] - 3'h1));
        if (p[3]) return 1'b1;
        return t ? (sec < n) : (sec >= 128 - n);
    endfunction
    // watchdog
    initial begin
        #600000;
        num_errors++;
        print_verdict();
    end
    // main sequence
    initial begin
        resetn = 1'b0;
        write_protect_n = 1'b1;
        ext_cycle_busy = 1'b0;
        ext_cycle_done = 1'b0;
        page_write_req = 1'b0;
        page_write_addr = 24'h000000;
        page_write_data = 8'h00;
        clear_all_req = 1'b0;
        void'($urandom(32'hFF7F));
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk(status_view, 8'h00);
        clr(1'b0);
        frame({8'h01, 8'hFC}, 16);
        settle();
        chk(status_view, 8'h00);
        frame(8'h06, 8);
        frame(64'h00FE, 15);
        settle();
        chk(status_view, 8'h02);
        clr(1'b1);
        for (int k = 0; k < 32; k++) begin
            d = {1'b0, k[4:0], 2'b11};
            wsr(d);
            chk(status_view, {d[7:2], 2'b00});
            frame({8'h05, 8'h00}, 16);
            chk(rx[7:0], {2'b00, d[5:2], 2'b00});
            frame(8'h06, 8);
            for (int j = 0; j < 8; j++) begin
                s = (j < 6) ? corner[j] : $urandom_range(127);
                pw({s[6:0], 17'($urandom)}, 8'($urandom), prot(d[5:2], d[6], s));
            end
            clr(d[5:2] == 4'h0);
            frame(8'h04, 8);
            pw(24'($urandom), 8'h00, 1'b1);
        end
        frame(8'h06, 8);
        frame({8'h01, 8'h00}, 16);
        frame({8'h05, 8'h00}, 16);
        chk(rx[1:0], 2'b11);
        frame({8'h03, 32'h0}, 40);
        chk(dv, 1'b0);
        settle();
        chk(status_view, 8'h00);
        wsr(8'h80);
        write_protect_n <= 1'b0;
        wsr(8'h3C);
        chk(status_view[7:2], 6'h20);
        frame({8'h05, 8'h00}, 16);
        chk(rx[7:0], 8'h82);
        write_protect_n <= 1'b1;
        wsr(8'h00);
        chk(status_view, 8'h00);
        ext_cycle_busy <= 1'b1;
        frame({8'h03, 32'h0}, 40);
        chk(dv, 1'b0);
        frame(8'h06, 8);
        chk(status_view, 8'h01);
        ext_cycle_busy <= 1'b0;
        frame(8'h06, 8);
        ext_cycle_done <= 1'b1;
        @(posedge sys_clk);
        ext_cycle_done <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(status_view, 8'h00);
        frame(8'h06, 8);
        for (int i = 0; i < 4; i++) begin
            b[i] = 8'($urandom);
            pw(24'hFFFFFE + 24'(i), b[i], 1'b0);
        end
        frame({8'h03, 24'hFFFFFE, 32'h0}, 64);
        chk(rx[31:0], {b[0], b[1], b[2], b[3]});
        frame({8'h03, 24'h000001, 4'h0}, 36);
        chk(rx[3:0], b[3][7:4]);
        chk(serial_out_oe_n, 1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire
